// ==== rtl/dcc_regs.vh ====
`ifndef DCC_REGS_VH
`define DCC_REGS_VH
// Register byte offsets on the APB port.
`define DCC_OFS_ENABLE 12'h000
`define DCC_OFS_SWREQ 12'h004
`define DCC_OFS_PRIO_SET 12'h008
`define DCC_OFS_PRIO_CLR 12'h00c
`define DCC_OFS_ALT_SEL 12'h010
`define DCC_OFS_STATUS 12'h014
`define DCC_OFS_PRI_BASE 12'h100
`define DCC_OFS_ALT_BASE 12'h120
// Descriptor word fields, as kept per channel and per descriptor.
`define DCC_CC_MSB 2
`define DCC_CC_LSB 0
`define DCC_NM1_MSB 13
`define DCC_NM1_LSB 4
`define DCC_RP_MSB 17
`define DCC_RP_LSB 14
`define DCC_CFG_W 18
`define DCC_CFG_RESET 18'h00000
// Cycle-type codes.
`define DCC_CC_INVALID 3'h0
`define DCC_CC_BASIC 3'h1
`define DCC_CC_AUTO 3'h2
`define DCC_CC_PINGPONG 3'h3
`define DCC_CC_MSG_PRI 3'h4
`define DCC_CC_MSG_ALT 3'h5
`define DCC_CC_PSG_PRI 3'h6
`define DCC_CC_PSG_ALT 3'h7
// Chunk sizing.
`define DCC_RP_SAT 4'ha
`define DCC_CHUNK_MAX 11'h400
`define DCC_SG_COPY 11'h004
`define DCC_SG_CFG_BEAT 2'h2
`endif

// ==== rtl/dcc_arbiter.v ====
// Fixed-priority pick: high level first, then the lowest channel number.
module dcc_arbiter #(
    parameter NCH = 8,
    parameter IW = 3
) (
    // Candidates and their priority level.
    input wire [NCH-1:0] i_req,
    input wire [NCH-1:0] i_high,
    // Winner.
    output reg o_valid,
    output reg [IW-1:0] o_idx
);
    integer k;

    // Scanning downwards lets the lower number overwrite; the high pass runs last to win.
    always @* begin
        o_valid = 1'b0;
        o_idx = {IW{1'b0}};
        for (k = NCH - 1; k >= 0; k = k - 1) begin
            if (i_req[k] && !i_high[k]) begin
                o_valid = 1'b1;
                o_idx = k[IW-1:0]; // R1
            end
        end
        for (k = NCH - 1; k >= 0; k = k - 1) begin
            if (i_req[k] && i_high[k]) begin
                o_valid = 1'b1;
                o_idx = k[IW-1:0]; // R2
            end
        end
    end
endmodule // dcc_arbiter

// ==== rtl/dcc_core.v ====
// How it works
// R1 - Same level: lower channel number wins.
// R2 - Software-set high level outranks default level.
// R3 - Chunk is two to exponent, saturating 1024.
// R4 - Arbitrate over all channels after each chunk.
// R5 - Codes 000-011: invalid, basic, auto, ping-pong.
// R6 - Codes 100-111: memory, peripheral scatter-gather.
// R7 - Re-arbitrate per chunk; remainder is last chunk.
// R8 - Software avoids large exponent on low channels.
// R9 - Completed cycle writes invalid cycle type back.
// R10 - Basic: one chunk per request, then arbitrate.
// R11 - Count zero: done pulse for one cycle; scatter-gather codes 100-111 give no done.
// R12 - Auto-request: one request finishes whole cycle.
// R13 - Ping-pong alternates primary and alternate descriptors.
// R14 - Ping-pong ends on invalid or channel disable.
// R15 - Ping-pong chunks each need a fresh request.
// R16 - Next ping-pong half waits for new request.
// R17 - Software ends ping-pong with basic descriptor.
// R18 - Memory scatter-gather: four primary, then alternate.
// R19 - Scatter-gather stops on basic or invalid.
// R20 - Only enabled, requesting channels enter arbitration.
`include "dcc_regs.vh"
module dcc_core #(
    parameter NCH = 8,
    parameter CW = 3
) (
    // Clock and reset.
    input wire I_MCLK,
    input wire I_RESET,
    // APB slave.
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output wire O_PREADY,
    output reg O_PSLVERR,
    // Peripheral request pins.
    input wire [NCH-1:0] I_DMA_REQ,
    // Transfer engine toward the system bus.
    output wire O_XFER_REQ,
    output reg [CW-1:0] O_XFER_CHAN,
    output reg O_XFER_ALT,
    input wire I_XFER_ACK,
    input wire [31:0] I_XFER_RDATA,
    // Per-channel completion.
    output reg [NCH-1:0] O_DONE
);
    localparam ST_IDLE = 2'h0;
    localparam ST_LOAD = 2'h1;
    localparam ST_XFER = 2'h2;
    localparam ST_WBACK = 2'h3;
    localparam [11:0] PRI_BASE = `DCC_OFS_PRI_BASE;
    localparam [11:0] ALT_BASE = `DCC_OFS_ALT_BASE;

    // Chunk length for an exponent code.
    function [10:0] chunk_len;
        input [3:0] rp;
        begin
            if (rp >= `DCC_RP_SAT) begin
                chunk_len = `DCC_CHUNK_MAX; // R3
            end else begin
                chunk_len = 11'h001 << rp; // R3
            end
        end
    endfunction

    // Primary halves of either scatter-gather flavour.
    function is_sg_pri;
        input [2:0] cc;
        begin
            is_sg_pri = (cc == `DCC_CC_MSG_PRI) || (cc == `DCC_CC_PSG_PRI); // R6
        end
    endfunction

    reg [NCH-1:0] req_s1;
    reg [NCH-1:0] req_s2;
    reg [NCH-1:0] req_s3;
    reg [NCH-1:0] req_level;
    reg [NCH-1:0] pending;
    reg [NCH-1:0] autoreq;
    reg [NCH-1:0] enable;
    reg [NCH-1:0] high_prio;
    reg [NCH-1:0] alt_sel;
    reg [`DCC_CFG_W-1:0] pri_cfg [0:NCH-1];
    reg [`DCC_CFG_W-1:0] alt_cfg [0:NCH-1];
    reg [1:0] state;
    reg [CW-1:0] cur_ch;
    reg cur_alt;
    reg [2:0] cur_cc;
    reg [10:0] cur_rem;
    reg [10:0] cur_cnt;
    reg [1:0] beat;
    reg [31:0] rd_data;
    reg rd_hit;
    reg [10:0] want;
    reg [NCH-1:0] next_pending;
    reg [NCH-1:0] grant_clr;
    reg [NCH-1:0] sw_set;
    wire [NCH-1:0] req_agree_hi;
    wire [NCH-1:0] eligible;
    wire arb_valid;
    wire [CW-1:0] arb_idx;
    wire [`DCC_CFG_W-1:0] sel_cfg;
    wire [10:0] sel_rem;
    wire wr_en;
    wire setup;
    wire [CW-1:0] wr_idx;
    wire complete;

    assign O_PREADY = 1'b1;
    assign setup = I_PSEL & ~I_PENABLE;
    assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
    assign wr_idx = I_PADDR[CW+1:2];
    assign O_XFER_REQ = (state == ST_XFER);
    assign complete = (cur_rem == 11'h000);

    // A pin counts as newly high only once the last two stages agree on it.
    assign req_agree_hi = req_s2 & req_s3 & ~req_level;
    assign eligible = enable & (pending | autoreq); // R20

    // Pin request synchroniser, three stages.
    always @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            req_s1 <= {NCH{1'b0}};
            req_s2 <= {NCH{1'b0}};
            req_s3 <= {NCH{1'b0}};
            req_level <= {NCH{1'b0}};
        end else begin
            req_s1 <= I_DMA_REQ;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            req_level <= (req_s2 & req_s3) | (req_level & (req_s2 | req_s3));
        end
    end

    dcc_arbiter #(
        .NCH(NCH),
        .IW(CW)
    ) u_arb (
        .i_req(eligible),
        .i_high(high_prio),
        .o_valid(arb_valid),
        .o_idx(arb_idx)
    );

    // Descriptor of the granted channel, on the descriptor it currently points to.
    assign sel_cfg = alt_sel[cur_ch] ? alt_cfg[cur_ch] : pri_cfg[cur_ch];
    assign sel_rem = {1'b0, sel_cfg[`DCC_NM1_MSB:`DCC_NM1_LSB]} + 11'h001;

    // Chunk for the fetched descriptor; the primary copy of scatter-gather is four, or the remainder if that is less.
    always @* begin
        if (is_sg_pri(sel_cfg[`DCC_CC_MSB:`DCC_CC_LSB])) begin
            want = `DCC_SG_COPY; // R18
        end else begin
            want = chunk_len(sel_cfg[`DCC_RP_MSB:`DCC_RP_LSB]); // R3
        end
        if (sel_rem < want) begin
            want = sel_rem; // R7
        end
    end

    // Pending requests: a new request in the grant cycle is kept, set beats clear.
    always @* begin
        grant_clr = {NCH{1'b0}};
        sw_set = {NCH{1'b0}};
        if (state == ST_IDLE && arb_valid) begin
            grant_clr[arb_idx] = 1'b1; // R10
        end
        if (wr_en && I_PADDR == `DCC_OFS_SWREQ) begin
            sw_set = I_PWDATA[NCH-1:0];
        end
        next_pending = (pending & ~grant_clr) | req_agree_hi | sw_set; // R15
    end

    // APB read mux, sampled in the setup phase so read data leaves a flop.
    always @* begin
        rd_hit = 1'b1;
        rd_data = 32'h00000000;
        if (I_PADDR == `DCC_OFS_ENABLE) begin
            rd_data[NCH-1:0] = enable;
        end else if (I_PADDR == `DCC_OFS_SWREQ) begin
            rd_data = 32'h00000000;
        end else if (I_PADDR == `DCC_OFS_PRIO_SET || I_PADDR == `DCC_OFS_PRIO_CLR) begin
            rd_data[NCH-1:0] = high_prio;
        end else if (I_PADDR == `DCC_OFS_ALT_SEL) begin
            rd_data[NCH-1:0] = alt_sel;
        end else if (I_PADDR == `DCC_OFS_STATUS) begin
            rd_data[7:0] = pending;
            rd_data[15:8] = autoreq;
            rd_data[18:16] = cur_ch;
            rd_data[20:19] = state;
        end else if (I_PADDR[11:5] == PRI_BASE[11:5] && I_PADDR[1:0] == 2'h0) begin
            rd_data[`DCC_CFG_W-1:0] = pri_cfg[wr_idx];
        end else if (I_PADDR[11:5] == ALT_BASE[11:5] && I_PADDR[1:0] == 2'h0) begin
            rd_data[`DCC_CFG_W-1:0] = alt_cfg[wr_idx];
        end else begin
            rd_hit = 1'b0;
        end
    end

    // APB answer flops: zero wait states, error on an unmapped address.
    always @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_PRDATA <= 32'h00000000;
            O_PSLVERR <= 1'b0;
        end else if (setup) begin
            O_PRDATA <= rd_data;
            O_PSLVERR <= ~rd_hit;
        end
    end

    // Software-owned control bits.
    always @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            enable <= {NCH{1'b0}};
            high_prio <= {NCH{1'b0}};
        end else if (wr_en) begin
            if (I_PADDR == `DCC_OFS_ENABLE) begin
                enable <= I_PWDATA[NCH-1:0]; // R14
            end
            if (I_PADDR == `DCC_OFS_PRIO_SET) begin
                high_prio <= high_prio | I_PWDATA[NCH-1:0]; // R2
            end
            if (I_PADDR == `DCC_OFS_PRIO_CLR) begin
                high_prio <= high_prio & ~I_PWDATA[NCH-1:0]; // R2
            end
        end
    end

    // Descriptor store and descriptor select; the engine's own updates win over
    // a software write in the same cycle so a write-back is never lost.
    integer i;
    always @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            for (i = 0; i < NCH; i = i + 1) begin
                pri_cfg[i] <= `DCC_CFG_RESET;
                alt_cfg[i] <= `DCC_CFG_RESET;
            end
            alt_sel <= {NCH{1'b0}};
        end else begin
            if (wr_en && I_PADDR[11:5] == PRI_BASE[11:5]) begin
                pri_cfg[wr_idx] <= I_PWDATA[`DCC_CFG_W-1:0];
            end
            if (wr_en && I_PADDR[11:5] == ALT_BASE[11:5]) begin
                alt_cfg[wr_idx] <= I_PWDATA[`DCC_CFG_W-1:0];
            end
            if (wr_en && I_PADDR == `DCC_OFS_ALT_SEL) begin
                alt_sel <= I_PWDATA[NCH-1:0];
            end
            // The primary copy writes the alternate descriptor; its control word
            // is the third beat of each group of four.
            if (state == ST_XFER && I_XFER_ACK && !cur_alt && is_sg_pri(cur_cc)
                    && beat == `DCC_SG_CFG_BEAT) begin
                alt_cfg[cur_ch] <= I_XFER_RDATA[`DCC_CFG_W-1:0]; // R18
            end
            if (state == ST_WBACK) begin
                if (complete) begin
                    if (cur_alt) begin
                        alt_cfg[cur_ch][`DCC_CC_MSB:`DCC_CC_LSB] <= `DCC_CC_INVALID; // R9
                    end else begin
                        pri_cfg[cur_ch][`DCC_CC_MSB:`DCC_CC_LSB] <= `DCC_CC_INVALID; // R9
                    end
                end else if (cur_alt) begin
                    alt_cfg[cur_ch][`DCC_NM1_MSB:`DCC_NM1_LSB] <= cur_rem[9:0] - 10'h001;
                end else begin
                    pri_cfg[cur_ch][`DCC_NM1_MSB:`DCC_NM1_LSB] <= cur_rem[9:0] - 10'h001;
                end
                case (cur_cc)
                    `DCC_CC_PINGPONG: begin
                        if (complete) begin
                            alt_sel[cur_ch] <= ~cur_alt; // R13
                        end
                    end
                    `DCC_CC_MSG_PRI, `DCC_CC_PSG_PRI: begin
                        alt_sel[cur_ch] <= 1'b1; // R18
                    end
                    `DCC_CC_MSG_ALT, `DCC_CC_PSG_ALT: begin
                        if (complete) begin
                            alt_sel[cur_ch] <= 1'b0; // R18
                        end
                    end
                    default: begin
                        alt_sel[cur_ch] <= alt_sel[cur_ch];
                    end
                endcase
            end
        end
    end

    // Request bookkeeping: auto-request keeps a channel eligible between chunks.
    always @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            pending <= {NCH{1'b0}};
            autoreq <= {NCH{1'b0}};
        end else begin
            pending <= next_pending;
            if (state == ST_LOAD && sel_cfg[`DCC_CC_MSB:`DCC_CC_LSB] == `DCC_CC_INVALID) begin
                autoreq[cur_ch] <= 1'b0; // R14
            end else if (state == ST_WBACK) begin
                case (cur_cc)
                    `DCC_CC_AUTO, `DCC_CC_MSG_ALT: begin
                        autoreq[cur_ch] <= ~complete | (cur_cc == `DCC_CC_MSG_ALT); // R12
                    end
                    `DCC_CC_MSG_PRI, `DCC_CC_PSG_PRI: begin
                        autoreq[cur_ch] <= 1'b1; // R18
                    end
                    `DCC_CC_PSG_ALT: begin
                        autoreq[cur_ch] <= ~complete;
                    end
                    default: begin
                        autoreq[cur_ch] <= 1'b0; // R10
                    end
                endcase
            end
        end
    end

    // Cycle sequencer: arbitrate, fetch, move one chunk, write back.
    always @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            state <= ST_IDLE;
            cur_ch <= {CW{1'b0}};
            cur_alt <= 1'b0;
            cur_cc <= `DCC_CC_INVALID;
            cur_rem <= 11'h000;
            cur_cnt <= 11'h000;
            beat <= 2'h0;
            O_XFER_CHAN <= {CW{1'b0}};
            O_XFER_ALT <= 1'b0;
            O_DONE <= {NCH{1'b0}};
        end else begin
            O_DONE <= {NCH{1'b0}};
            case (state)
                ST_IDLE: begin
                    if (arb_valid) begin
                        cur_ch <= arb_idx; // R4
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // The descriptor is read for the channel latched at the grant: its
                    // pending bit is already cleared, so the arbiter may point elsewhere
                    // by now.
                    cur_alt <= alt_sel[cur_ch];
                    cur_cc <= sel_cfg[`DCC_CC_MSB:`DCC_CC_LSB]; // R5
                    cur_rem <= sel_rem;
                    cur_cnt <= want; // R7
                    beat <= 2'h0;
                    O_XFER_CHAN <= cur_ch;
                    O_XFER_ALT <= alt_sel[cur_ch];
                    if (sel_cfg[`DCC_CC_MSB:`DCC_CC_LSB] == `DCC_CC_INVALID) begin
                        state <= ST_IDLE; // R19
                    end else begin
                        state <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (I_XFER_ACK) begin
                        cur_cnt <= cur_cnt - 11'h001;
                        cur_rem <= cur_rem - 11'h001;
                        beat <= beat + 2'h1;
                        if (cur_cnt == 11'h001) begin
                            state <= ST_WBACK; // R7
                        end
                    end
                end
                ST_WBACK: begin
                    if (complete && !is_sg_pri(cur_cc) && cur_cc != `DCC_CC_MSG_ALT
                            && cur_cc != `DCC_CC_PSG_ALT) begin
                        O_DONE[cur_ch] <= 1'b1; // R11
                    end
                    state <= ST_IDLE; // R16
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // dcc_core

// ==== dv/dcc_asserts.sv ====
`include "dcc_regs.vh"
module dcc_asserts #(
    parameter NCH = 8,
    parameter CW = 3
) (
    // Clock, reset and register port.
    input wire I_MCLK,
    input wire I_RESET,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire [31:0] O_PRDATA,
    input wire O_PREADY,
    input wire O_PSLVERR,
    // Requests and transfer engine.
    input wire [NCH-1:0] I_DMA_REQ,
    input wire O_XFER_REQ,
    input wire [CW-1:0] O_XFER_CHAN,
    input wire O_XFER_ALT,
    input wire I_XFER_ACK,
    input wire [31:0] I_XFER_RDATA,
    // Completion.
    input wire [NCH-1:0] O_DONE
);
    logic [NCH-1:0] en;
    logic [11:0] nack;
    // The enable shadow lets a grant be judged without peeking inside the block.
    always @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            en <= '0;
            nack <= 12'h000;
        end else begin
            if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == `DCC_OFS_ENABLE)
                en <= I_PWDATA[NCH-1:0];
            nack <= O_XFER_REQ ? nack + {11'h000, I_XFER_ACK} : 12'h000;
        end
    end
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);
    a_done_pulse: assert property (|O_DONE |=> (O_DONE & $past(O_DONE)) == '0)
        else $error("done stood longer than one cycle");
    a_done_single: assert property ($onehot0(O_DONE))
        else $error("several done bits at once");
    a_done_after: assert property (|O_DONE |-> $past(O_XFER_REQ, 2) && !O_XFER_REQ)
        else $error("done not two cycles after a chunk");
    a_chunk_hold: assert property (O_XFER_REQ && !I_XFER_ACK |=> O_XFER_REQ
        && $stable(O_XFER_CHAN) && $stable(O_XFER_ALT))
        else $error("chunk dropped or changed without ack");
    a_rearb_gap: assert property ($fell(O_XFER_REQ) |-> !O_XFER_REQ [*2])
        else $error("no arbitration gap after a chunk");
    a_grant_enabled: assert property ($rose(O_XFER_REQ) |-> en[O_XFER_CHAN])
        else $error("disabled channel granted");
    a_chunk_max: assert property (nack <= `DCC_CHUNK_MAX)
        else $error("chunk longer than 1024 transfers");
    a_err_data: assert property (I_PSEL && I_PENABLE && O_PSLVERR |-> O_PRDATA == 32'h0)
        else $error("error read returned data");
    c_done: cover property (|O_DONE);
    c_alt: cover property ($rose(O_XFER_REQ) && O_XFER_ALT);
    c_err: cover property (I_PSEL && I_PENABLE && O_PSLVERR);
endmodule // dcc_asserts

// ==== dv/dcc_bus_model.sv ====
module dcc_bus_model (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Engine side.
    input wire req,
    output logic ack,
    output logic [31:0] rdata,
    // Stall mode and the word returned on reads.
    input wire slow,
    input wire [31:0] word
);
    timeunit 1ns;
    timeprecision 1ps;
    // A stalled bus acks every other cycle; between acks the data lines show junk.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            rdata <= 32'h0;
        end else begin
            ack <= req && !(slow && ack);
            rdata <= (req && !(slow && ack)) ? word : ~rdata;
        end
    end
endmodule // dcc_bus_model

// ==== dv/dcc_tb.sv ====
`include "dcc_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, slow = 1'b0, er, calt;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, word = 32'h0, rd;
    logic [7:0] dreq = 8'h00;
    wire [31:0] prdata, rdata;
    wire pready, pslverr, xreq, xalt, ack;
    wire [2:0] xch;
    wire [7:0] done;
    int n_errors = 0, checks = 0, cur = 0;
    logic [2:0] qch[$], cch;
    logic qalt[$];
    int qlen[$];
    logic [7:0] qdone[$];
    // The clock runs at 40 MHz.
    always #12.5 clk = ~clk;
    dcc_core dut (.I_MCLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_DMA_REQ(dreq), .O_XFER_REQ(xreq),
        .O_XFER_CHAN(xch), .O_XFER_ALT(xalt), .I_XFER_ACK(ack), .I_XFER_RDATA(rdata),
        .O_DONE(done));
    dcc_bus_model mem (.clk(clk), .rst(rst), .req(xreq), .ack(ack), .rdata(rdata),
        .slow(slow), .word(word));
    // Chunks are logged when the request drops; done pulses are logged as they stand.
    always @(posedge clk) begin
        if (xreq && ack) begin
            cur = cur + 1;
            cch = xch;
            calt = xalt;
        end else if (!xreq && cur > 0) begin
            qch.push_back(cch);
            qalt.push_back(calt);
            qlen.push_back(cur);
            cur = 0;
        end
        if (!rst && done !== 8'h00)
            qdone.push_back(done);
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Read data and error are taken at the edge that completes the access.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    function logic [31:0] dw(input logic [3:0] rp, input logic [9:0] nm1, input logic [2:0] cc);
        return {14'h0000, rp, nm1, 1'b0, cc};
    endfunction
    task pin(input int i);
        @(posedge clk);
        dreq[i] <= 1'b1;
        repeat (6) @(posedge clk);
        dreq[i] <= 1'b0;
    endtask
    task await(input int n);
        int t;
        t = 0;
        while (qlen.size() < n && t < 3000) begin
            @(posedge clk);
            t++;
        end
        repeat (4) @(posedge clk);
    endtask
    task chunk(input logic [2:0] ch, input logic alt, input int len);
        if (qlen.size() == 0)
            chk("chunk present", 32'h0, 32'h1);
        else begin
            chk("chunk channel", qch.pop_front(), ch);
            chk("chunk alt", qalt.pop_front(), alt);
            chk("chunk length", qlen.pop_front(), len);
        end
    endtask
    task dn(input logic [7:0] exp);
        chk("done", qdone.size() ? qdone.pop_front() : 8'h00, exp);
    endtask
    // Nothing may move while no fresh request stands.
    task quiet;
        repeat (30) @(posedge clk);
        chk("idle chunks", qlen.size(), 0);
        dn(8'h00);
    endtask
    task t_regs;
        logic [11:0] a[4];
        a = '{`DCC_OFS_ENABLE, `DCC_OFS_SWREQ, `DCC_OFS_ALT_SEL, `DCC_OFS_STATUS};
        foreach (a[i]) begin
            apb(1'b0, a[i], 32'h0);
            chk("reset value", rd, 32'h0);
        end
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `DCC_OFS_PRI_BASE + 12'h01c, dw(4'h3, 10'h005, c[2:0]));
            apb(1'b0, `DCC_OFS_PRI_BASE + 12'h01c, 32'h0);
            chk("cycle code", rd, dw(4'h3, 10'h005, c[2:0]));
        end
        apb(1'b1, `DCC_OFS_PRI_BASE + 12'h01c, 32'h0);
        apb(1'b1, `DCC_OFS_PRIO_SET, 32'h24);
        apb(1'b1, `DCC_OFS_PRIO_CLR, 32'h04);
        apb(1'b0, `DCC_OFS_PRIO_SET, 32'h0);
        chk("high priority", rd, 32'h20);
        apb(1'b1, `DCC_OFS_PRIO_CLR, 32'h20);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped error", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        $display("t_regs done");
    endtask
    task t_basic;
        apb(1'b1, `DCC_OFS_PRI_BASE, dw(4'h1, 10'h004, `DCC_CC_BASIC));
        apb(1'b1, `DCC_OFS_ENABLE, 32'h01);
        pin(0);
        await(1);
        chunk(3'h0, 1'b0, 2);
        quiet;
        pin(0);
        await(1);
        chunk(3'h0, 1'b0, 2);
        pin(0);
        await(1);
        chunk(3'h0, 1'b0, 1);
        dn(8'h01);
        apb(1'b0, `DCC_OFS_PRI_BASE, 32'h0);
        chk("code after done", rd[2:0], `DCC_CC_INVALID);
        pin(0);
        quiet;
        $display("t_basic done");
    endtask
    task t_prio;
        apb(1'b1, `DCC_OFS_ENABLE, 32'h28);
        for (int c = 3; c < 7; c++)
            apb(1'b1, `DCC_OFS_PRI_BASE + 4 * c, dw(4'h0, 10'h000, `DCC_CC_BASIC));
        apb(1'b1, `DCC_OFS_SWREQ, 32'h68);
        await(2);
        chunk(3'h3, 1'b0, 1);
        chunk(3'h5, 1'b0, 1);
        dn(8'h08);
        dn(8'h20);
        quiet;
        apb(1'b1, `DCC_OFS_PRIO_SET, 32'h20);
        apb(1'b1, `DCC_OFS_PRI_BASE + 12'h00c, dw(4'h0, 10'h000, `DCC_CC_BASIC));
        apb(1'b1, `DCC_OFS_PRI_BASE + 12'h014, dw(4'h0, 10'h000, `DCC_CC_BASIC));
        apb(1'b1, `DCC_OFS_SWREQ, 32'h28);
        await(2);
        chunk(3'h5, 1'b0, 1);
        chunk(3'h3, 1'b0, 1);
        apb(1'b1, `DCC_OFS_PRIO_CLR, 32'h20);
        apb(1'b1, `DCC_OFS_ENABLE, 32'h40);
        await(1);
        chunk(3'h6, 1'b0, 1);
        qdone.delete();
        $display("t_prio done");
    endtask
    task t_auto;
        apb(1'b1, `DCC_OFS_ENABLE, 32'h02);
        apb(1'b1, `DCC_OFS_PRI_BASE + 12'h004, dw(4'h9, 10'h3ff, `DCC_CC_AUTO));
        apb(1'b1, `DCC_OFS_SWREQ, 32'h02);
        await(2);
        chunk(3'h1, 1'b0, 512);
        chunk(3'h1, 1'b0, 512);
        dn(8'h02);
        apb(1'b1, `DCC_OFS_PRI_BASE + 12'h004, dw(4'hf, 10'h3e7, `DCC_CC_AUTO));
        apb(1'b1, `DCC_OFS_SWREQ, 32'h02);
        await(1);
        chunk(3'h1, 1'b0, 1000);
        dn(8'h02);
        $display("t_auto done");
    endtask
    task t_pp;
        apb(1'b1, `DCC_OFS_ENABLE, 32'h04);
        apb(1'b1, `DCC_OFS_PRI_BASE + 12'h008, dw(4'h1, 10'h002, `DCC_CC_PINGPONG));
        apb(1'b1, `DCC_OFS_ALT_BASE + 12'h008, dw(4'h0, 10'h000, `DCC_CC_BASIC));
        apb(1'b1, `DCC_OFS_SWREQ, 32'h04);
        await(1);
        chunk(3'h2, 1'b0, 2);
        quiet;
        apb(1'b1, `DCC_OFS_SWREQ, 32'h04);
        await(1);
        chunk(3'h2, 1'b0, 1);
        dn(8'h04);
        quiet;
        apb(1'b1, `DCC_OFS_SWREQ, 32'h04);
        await(1);
        chunk(3'h2, 1'b1, 1);
        dn(8'h04);
        apb(1'b1, `DCC_OFS_SWREQ, 32'h04);
        quiet;
        $display("t_pp done");
    endtask
    task t_sg;
        slow <= 1'b1;
        word <= dw(4'h1, 10'h001, `DCC_CC_MSG_ALT);
        apb(1'b1, `DCC_OFS_ENABLE, 32'h10);
        apb(1'b1, `DCC_OFS_PRI_BASE + 12'h010, dw(4'h2, 10'h007, `DCC_CC_MSG_PRI));
        apb(1'b1, `DCC_OFS_SWREQ, 32'h10);
        await(1);
        chunk(3'h4, 1'b0, 4);
        word <= dw(4'h0, 10'h001, `DCC_CC_AUTO);
        await(4);
        chunk(3'h4, 1'b1, 2);
        chunk(3'h4, 1'b0, 4);
        chunk(3'h4, 1'b1, 1);
        chunk(3'h4, 1'b1, 1);
        dn(8'h10);
        quiet;
        apb(1'b0, `DCC_OFS_PRI_BASE + 12'h010, 32'h0);
        chk("primary code", rd[2:0], `DCC_CC_INVALID);
        word <= dw(4'h0, 10'h000, `DCC_CC_BASIC);
        apb(1'b1, `DCC_OFS_ALT_SEL, 32'h00);
        apb(1'b1, `DCC_OFS_PRI_BASE + 12'h010, dw(4'h2, 10'h003, `DCC_CC_PSG_PRI));
        apb(1'b1, `DCC_OFS_SWREQ, 32'h10);
        await(2);
        chunk(3'h4, 1'b0, 4);
        chunk(3'h4, 1'b1, 1);
        dn(8'h10);
        $display("t_sg done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // The whole run needs well under 10000 cycles, so 20000 means a hang.
    initial begin
        #(25 * 20000);
        n_errors++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_basic;
        t_prio;
        t_auto;
        t_pp;
        t_sg;
        finish_test;
    end
endmodule // testbench
bind dcc_core dcc_asserts #(.NCH(NCH), .CW(CW)) u_chk (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_DMA_REQ(I_DMA_REQ), .O_XFER_REQ(O_XFER_REQ), .O_XFER_CHAN(O_XFER_CHAN),
    .O_XFER_ALT(O_XFER_ALT), .I_XFER_ACK(I_XFER_ACK), .I_XFER_RDATA(I_XFER_RDATA),
    .O_DONE(O_DONE));
